// *** inc/hcs_params.svh ***
// Constants shared by both ends of the host control serial port.
`ifndef HCS_PARAMS_SVH
`define HCS_PARAMS_SVH
`define HCS_DEV_ADDR6   6'h0e
`define HCS_CLK_KHZ     100000
`define HCS_SCL_KHZ     400
`define HCS_SCL_STD_KHZ 100
`define HCS_QTR_CYC(k)  ((`HCS_CLK_KHZ + 4 * (k) - 1) / (4 * (k)))
`define HCS_PY_LO       16'h4000
`define HCS_PY_HI       16'h47ff
`define HCS_GCR_ADDR    16'h0fff
`define HCS_REGBLK_TOP  12'h0fe
`define HCS_WLEN_SHORT  2'h2
`define HCS_WLEN_LONG   2'h3
`endif

// *** inc/hcs_pkg.sv ***
// Types and the word length decode of the host control serial port.
`include "hcs_params.svh"
package hcs_pkg;
   typedef logic [15:0] hcs_addr_type;
   typedef logic [23:0] hcs_word_type;
   typedef enum logic [6:0] {
      D_IDLE = 7'h01, D_ADR = 7'h02, D_AACK = 7'h04, D_RXB = 7'h08,
      D_RACK = 7'h10, D_TXB = 7'h20, D_MACK = 7'h40
   } hcs_dstate_type;
   typedef enum logic [4:0] {
      H_IDLE = 5'h01, H_START = 5'h02, H_BYTE = 5'h04, H_NEXT = 5'h08,
      H_STOP = 5'h10
   } hcs_hstate_type;
   function automatic logic [1:0] hcs_wlen(input hcs_addr_type a);
      if ((a >= `HCS_PY_LO && a <= `HCS_PY_HI) || a == `HCS_GCR_ADDR)
         return `HCS_WLEN_SHORT;
      return `HCS_WLEN_LONG;
   endfunction : hcs_wlen
endpackage : hcs_pkg

// *** inc/hcs_i2c_if.sv ***
// Two-wire bus joining the host end and the device end.
`timescale 1ns/1ns
interface hcs_i2c_if;
   logic scl;
   logic sda_h_o;
   logic sda_h_oe;
   logic sda_d_o;
   logic sda_d_oe;
   logic sda;
   // Open drain: a driver that enables pulls low, otherwise pulled up.
   assign sda = !((sda_h_oe && !sda_h_o) || (sda_d_oe && !sda_d_o));
   modport dev (input scl, input sda, output sda_d_o, output sda_d_oe);
   modport host (output scl, output sda_h_o, output sda_h_oe, input sda);
endinterface : hcs_i2c_if

// *** rtl/hcs_dev_end.sv ***
// Device end: two-wire slave port into the signal processor memories.
`timescale 1ns/1ns
`include "hcs_params.svh"
// Operation
// - Fast-mode slave, also usable at standard rate.
// - Only first byte after start selects device.
// - Address is 001110 plus select pin, then direction.
// - Clock only sampled; data line bidirectional.
// - Two-byte words for primary second memory.
// - Word length from memory address; never four.
// - Read begins with acknowledged write addressing.
// - Memory address high then low, both acknowledged.
// - Repeated start with read direction, then transmit.
// - Read groups of two or three bytes.
// - Master not-acknowledge ends read; release data.
// - Read data loaded on host transfer instruction.
// - Program/memory and data flow command classes.
// - Select pin feeds test serial input.
// - General control register carries two bytes.
// - Secondary register block always three bytes.
module hcs_dev_end (
   input  wire logic         clk_sys_in,
   input  wire logic         nrst_in,
   input  wire logic         ce_in,
   input  wire logic         addr_sel_in,
   input  wire logic         test_mode_in,
   input  wire logic         host_xfer_in,
   input  hcs_pkg::hcs_word_type mem_rdata_in,
   hcs_i2c_if.dev            bus,
   output hcs_pkg::hcs_addr_type mem_addr_out,
   output hcs_pkg::hcs_word_type mem_wdata_out,
   output logic              mem_wr_out,
   output logic              mem_rd_out,
   output logic              cmd_class_out,
   output logic              test_sdi_out,
   output logic              active_out
);
   import hcs_pkg::*;

   logic           scl1_r, scl2_r, scl3_r;
   logic           sda1_r, sda2_r, sda3_r;
   logic           sel1_r, sel2_r;
   hcs_dstate_type st_r;
   logic [3:0]     cnt_r;
   logic [7:0]     sh_r;
   logic [7:0]     tsh_r;
   logic [1:0]     bidx_r;
   logic [1:0]     gidx_r;
   logic           rw_r;
   logic           nack_r;
   logic           oe_r;
   logic           sdo_r;
   hcs_addr_type   addr_r;
   hcs_word_type   wword_r;
   hcs_word_type   data_r;
   hcs_word_type   gword_r;
   logic           pend_r;
   hcs_addr_type   maddr_r;
   hcs_word_type   mwdata_r;
   logic           mwr_r;
   logic           mrd_r;
   logic           class_r;
   logic           tsdi_r;
   logic           act_r;
   logic [1:0]     wlen;
   logic           scl_rise;
   logic           scl_fall;
   logic           start_ev;
   logic           stop_ev;
   hcs_word_type   txw;
   logic [7:0]     txb;
   logic [1:0]     kidx;

   // Bus and strap pins cross into the clock domain through two stages.
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         scl1_r <= 1'b1;
         scl2_r <= 1'b1;
         scl3_r <= 1'b1;
         sda1_r <= 1'b1;
         sda2_r <= 1'b1;
         sda3_r <= 1'b1;
         sel1_r <= 1'b0;
         sel2_r <= 1'b0;
      end else if (ce_in) begin
         scl1_r <= bus.scl;
         scl2_r <= scl1_r;
         scl3_r <= scl2_r;
         sda1_r <= bus.sda;
         sda2_r <= sda1_r;
         sda3_r <= sda2_r;
         sel1_r <= addr_sel_in;
         sel2_r <= sel1_r;
      end
   end

   // At 100 MHz a 400 kHz bit spans 250 cycles, so sampled edges suffice.
   assign scl_rise = scl2_r & ~scl3_r;
   assign scl_fall = ~scl2_r & scl3_r;
   assign start_ev = scl2_r & scl3_r & sda3_r & ~sda2_r;
   assign stop_ev  = scl2_r & scl3_r & ~sda3_r & sda2_r;

   assign wlen = hcs_wlen(addr_r);

   // Byte of the current group to send, most significant first.
   always_comb begin
      txw  = (gidx_r == 2'h0) ? data_r : gword_r;
      kidx = gidx_r + (2'h3 - wlen);
      case (kidx)
         2'h0:    txb = txw[23:16];
         2'h1:    txb = txw[15:8];
         default: txb = txw[7:0];
      endcase
   end

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_r     <= D_IDLE;
         cnt_r    <= 4'h0;
         sh_r     <= 8'h00;
         tsh_r    <= 8'h00;
         bidx_r   <= 2'h0;
         gidx_r   <= 2'h0;
         rw_r     <= 1'b0;
         nack_r   <= 1'b0;
         oe_r     <= 1'b0;
         addr_r   <= 16'h0000;
         wword_r  <= 24'h000000;
         gword_r  <= 24'h000000;
         maddr_r  <= 16'h0000;
         mwdata_r <= 24'h000000;
         mwr_r    <= 1'b0;
         mrd_r    <= 1'b0;
      end else if (ce_in) begin
         mwr_r <= 1'b0;
         mrd_r <= 1'b0;
         if (start_ev) begin
            st_r   <= D_ADR;
            cnt_r  <= 4'h0;
            bidx_r <= 2'h0;
            oe_r   <= 1'b0;
         end else if (stop_ev) begin
            st_r <= D_IDLE;
            oe_r <= 1'b0;
         end else begin
            case (st_r)
               D_ADR, D_RXB: begin
                  if (scl_rise) begin
                     sh_r  <= {sh_r[6:0], sda2_r};
                     cnt_r <= cnt_r + 4'h1;
                  end else if (scl_fall && cnt_r == 4'h8) begin
                     if (st_r == D_ADR) begin
                        // Any later byte is data, never a new address.
                        if (sh_r[7:1] == {`HCS_DEV_ADDR6, sel2_r}) begin
                           rw_r <= sh_r[0];
                           oe_r <= 1'b1;
                           st_r <= D_AACK;
                        end else begin
                           st_r <= D_IDLE;
                        end
                     end else begin
                        oe_r <= 1'b1;
                        st_r <= D_RACK;
                        if (bidx_r == 2'h0) begin
                           addr_r[15:8] <= sh_r;
                           bidx_r       <= 2'h1;
                        end else if (bidx_r == 2'h1) begin
                           addr_r[7:0] <= sh_r;
                           bidx_r      <= 2'h2;
                           gidx_r      <= 2'h0;
                           maddr_r     <= {addr_r[15:8], sh_r};
                           mrd_r       <= 1'b1;
                        end else begin
                           wword_r <= {wword_r[15:0], sh_r};
                           if (gidx_r == wlen - 2'h1) begin
                              maddr_r <= addr_r;
                              mwr_r   <= 1'b1;
                              if (wlen == `HCS_WLEN_SHORT)
                                 mwdata_r <= {8'h00, wword_r[7:0], sh_r};
                              else
                                 mwdata_r <= {wword_r[15:0], sh_r};
                              addr_r <= addr_r + 16'h0001;
                              gidx_r <= 2'h0;
                           end else begin
                              gidx_r <= gidx_r + 2'h1;
                           end
                        end
                     end
                  end
               end
               D_RACK: begin
                  if (scl_fall) begin
                     oe_r  <= 1'b0;
                     cnt_r <= 4'h0;
                     st_r  <= D_RXB;
                  end
               end
               D_AACK, D_MACK: begin
                  if (scl_rise && st_r == D_MACK) begin
                     nack_r <= sda2_r;
                  end else if (scl_fall) begin
                     if (st_r == D_MACK && nack_r) begin
                        oe_r <= 1'b0;
                        st_r <= D_IDLE;
                     end else if (rw_r) begin
                        if (gidx_r == 2'h0)
                           gword_r <= data_r;
                        oe_r  <= ~txb[7];
                        tsh_r <= {txb[6:0], 1'b0};
                        cnt_r <= 4'h1;
                        st_r  <= D_TXB;
                        if (gidx_r == wlen - 2'h1) begin
                           gidx_r  <= 2'h0;
                           addr_r  <= addr_r + 16'h0001;
                           maddr_r <= addr_r + 16'h0001;
                           mrd_r   <= 1'b1;
                        end else begin
                           gidx_r <= gidx_r + 2'h1;
                        end
                     end else begin
                        oe_r  <= 1'b0;
                        cnt_r <= 4'h0;
                        st_r  <= D_RXB;
                     end
                  end
               end
               D_TXB: begin
                  if (scl_fall) begin
                     if (cnt_r == 4'h8) begin
                        oe_r <= 1'b0;
                        st_r <= D_MACK;
                     end else begin
                        oe_r  <= ~tsh_r[7];
                        tsh_r <= {tsh_r[6:0], 1'b0};
                        cnt_r <= cnt_r + 4'h1;
                     end
                  end
               end
               default: st_r <= D_IDLE;
            endcase
         end
      end
   end

   // If the instruction has not run yet, the previous word is sent:
   // the port has no way to stretch the clock and wait for it.
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         data_r <= 24'h000000;
         pend_r <= 1'b0;
      end else if (ce_in) begin
         if (host_xfer_in && pend_r)
            data_r <= mem_rdata_in;
         // A request raised in the cycle of a transfer stays pending.
         if (mrd_r)
            pend_r <= 1'b1;
         else if (host_xfer_in)
            pend_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         class_r <= 1'b0;
         tsdi_r  <= 1'b0;
         act_r   <= 1'b0;
         sdo_r   <= 1'b0;
      end else if (ce_in) begin
         class_r <= (maddr_r == `HCS_GCR_ADDR) ||
                    (maddr_r[15:4] == `HCS_REGBLK_TOP);
         tsdi_r  <= test_mode_in & sel2_r;
         act_r   <= (st_r != D_IDLE);
         sdo_r   <= 1'b0;
      end
   end

   assign bus.sda_d_oe  = oe_r;
   assign bus.sda_d_o   = sdo_r;
   assign mem_addr_out  = maddr_r;
   assign mem_wdata_out = mwdata_r;
   assign mem_wr_out    = mwr_r;
   assign mem_rd_out    = mrd_r;
   assign cmd_class_out = class_r;
   assign test_sdi_out  = tsdi_r;
   assign active_out    = act_r;
endmodule : hcs_dev_end

// *** rtl/hcs_host_end.sv ***
// Host end: two-wire bus master issuing memory writes and reads.
`timescale 1ns/1ns
`include "hcs_params.svh"
module hcs_host_end #(
   parameter int SCL_KHZ = `HCS_SCL_KHZ
) (
   input  wire logic         clk_sys_in,
   input  wire logic         nrst_in,
   input  wire logic         ce_in,
   input  wire logic         cmd_go_in,
   input  wire logic         cmd_read_in,
   input  hcs_pkg::hcs_addr_type cmd_addr_in,
   input  hcs_pkg::hcs_word_type cmd_wdata_in,
   input  wire logic [7:0]   cmd_words_in,
   input  wire logic         addr_sel_in,
   hcs_i2c_if.host           bus,
   output logic              busy_out,
   output logic              done_out,
   output logic              nack_out,
   output hcs_pkg::hcs_word_type rdata_out,
   output logic              rvalid_out
);
   import hcs_pkg::*;

   localparam int QTR = `HCS_QTR_CYC(SCL_KHZ);
   if (SCL_KHZ < 1 || SCL_KHZ > `HCS_SCL_KHZ || QTR < 4)
      $error("SCL_KHZ out of range");

   localparam logic [2:0] S_DEVW = 3'h0, S_MAH = 3'h1, S_MAL = 3'h2,
                          S_DATA = 3'h3, S_RST = 3'h4, S_DEVR = 3'h5,
                          S_RD = 3'h6;

   logic           sda1_r, sda2_r;
   hcs_hstate_type st_r;
   logic [15:0]    qc_r;
   logic [1:0]     q_r;
   logic [3:0]     bitn_r;
   logic [7:0]     sh_r;
   logic [2:0]     seq_r;
   logic           rdb_r;
   logic           ack_r;
   logic           scl_r;
   logic           oe_r;
   logic           nack_r;
   logic           busy_r;
   logic           done_r;
   logic           rv_r;
   logic           rd_r;
   logic           sel_r;
   hcs_addr_type   addr_r;
   hcs_word_type   wsh_r;
   hcs_word_type   rword_r;
   hcs_word_type   rdat_r;
   logic [9:0]     left_r;
   logic [1:0]     gcnt_r;
   logic [1:0]     wlen;
   logic           tick;

   assign wlen = hcs_wlen(addr_r);
   assign tick = (st_r != H_IDLE) && (st_r != H_NEXT) &&
                 (qc_r == 16'(QTR - 1));

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sda1_r <= 1'b1;
         sda2_r <= 1'b1;
      end else if (ce_in) begin
         sda1_r <= bus.sda;
         sda2_r <= sda1_r;
      end
   end

   // Quarter-bit timer; the clock low and high halves are two quarters.
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in)
         qc_r <= 16'h0000;
      else if (ce_in) begin
         if (st_r == H_IDLE || st_r == H_NEXT || tick)
            qc_r <= 16'h0000;
         else
            qc_r <= qc_r + 16'h0001;
      end
   end

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_r    <= H_IDLE;
         q_r     <= 2'h0;
         bitn_r  <= 4'h0;
         sh_r    <= 8'h00;
         seq_r   <= S_DEVW;
         rdb_r   <= 1'b0;
         ack_r   <= 1'b0;
         scl_r   <= 1'b1;
         oe_r    <= 1'b0;
         nack_r  <= 1'b0;
         busy_r  <= 1'b0;
         done_r  <= 1'b0;
         rv_r    <= 1'b0;
         rd_r    <= 1'b0;
         sel_r   <= 1'b0;
         addr_r  <= 16'h0000;
         wsh_r   <= 24'h000000;
         rword_r <= 24'h000000;
         rdat_r  <= 24'h000000;
         left_r  <= 10'h000;
         gcnt_r  <= 2'h0;
      end else if (ce_in) begin
         done_r <= 1'b0;
         rv_r   <= 1'b0;
         if (tick)
            q_r <= q_r + 2'h1;
         case (st_r)
            H_IDLE: begin
               if (cmd_go_in) begin
                  busy_r <= 1'b1;
                  nack_r <= 1'b0;
                  rd_r   <= cmd_read_in;
                  sel_r  <= addr_sel_in;
                  addr_r <= cmd_addr_in;
                  seq_r  <= S_DEVW;
                  gcnt_r <= 2'h0;
                  rdb_r  <= 1'b0;
                  q_r    <= 2'h0;
                  st_r   <= H_START;
               end
            end
            H_START: begin
               if (tick) begin
                  case (q_r)
                     2'h0: oe_r <= 1'b0;
                     2'h1: scl_r <= 1'b1;
                     2'h2: oe_r <= 1'b1;
                     default: begin
                        scl_r <= 1'b0;
                        st_r  <= H_NEXT;
                     end
                  endcase
               end
            end
            H_BYTE: begin
               if (tick) begin
                  case (q_r)
                     2'h0: oe_r <= (bitn_r < 4'h8) ? (~rdb_r & ~sh_r[7])
                                                   : (rdb_r & ack_r);
                     2'h1: scl_r <= 1'b1;
                     2'h2: begin
                        if (bitn_r < 4'h8)
                           sh_r <= {sh_r[6:0], sda2_r};
                        else if (!rdb_r)
                           nack_r <= sda2_r;
                     end
                     default: begin
                        scl_r  <= 1'b0;
                        bitn_r <= bitn_r + 4'h1;
                        if (bitn_r == 4'h8) begin
                           bitn_r <= 4'h0;
                           st_r   <= H_NEXT;
                        end
                     end
                  endcase
               end
            end
            H_NEXT: begin
               st_r <= H_BYTE;
               if (rdb_r) begin
                  rword_r <= {rword_r[15:0], sh_r};
                  if (gcnt_r == wlen - 2'h1) begin
                     rv_r   <= 1'b1;
                     gcnt_r <= 2'h0;
                     if (wlen == `HCS_WLEN_SHORT)
                        rdat_r <= {8'h00, rword_r[7:0], sh_r};
                     else
                        rdat_r <= {rword_r[15:0], sh_r};
                  end else begin
                     gcnt_r <= gcnt_r + 2'h1;
                  end
               end
               rdb_r <= 1'b0;
               if (nack_r) begin
                  oe_r <= 1'b1;
                  st_r <= H_STOP;
               end else begin
                  case (seq_r)
                     S_DEVW: begin
                        sh_r  <= {`HCS_DEV_ADDR6, sel_r, 1'b0};
                        seq_r <= S_MAH;
                     end
                     S_MAH: begin
                        sh_r  <= addr_r[15:8];
                        seq_r <= S_MAL;
                     end
                     S_MAL: begin
                        sh_r  <= addr_r[7:0];
                        seq_r <= rd_r ? S_RST : S_DATA;
                        if (rd_r)
                           left_r <= 10'(cmd_words_in) * 10'(wlen);
                        else
                           left_r <= 10'(wlen);
                        wsh_r <= (wlen == `HCS_WLEN_SHORT) ?
                                 {cmd_wdata_in[15:0], 8'h00} : cmd_wdata_in;
                     end
                     S_DATA, S_RD: begin
                        if (left_r == 10'h000) begin
                           oe_r <= 1'b1;
                           st_r <= H_STOP;
                        end else begin
                           left_r <= left_r - 10'h001;
                           sh_r   <= wsh_r[23:16];
                           wsh_r  <= {wsh_r[15:0], 8'h00};
                           rdb_r  <= (seq_r == S_RD);
                           ack_r  <= (left_r != 10'h001);
                        end
                     end
                     S_RST: begin
                        st_r  <= H_START;
                        seq_r <= S_DEVR;
                     end
                     S_DEVR: begin
                        sh_r  <= {`HCS_DEV_ADDR6, sel_r, 1'b1};
                        seq_r <= S_RD;
                     end
                     default: st_r <= H_STOP;
                  endcase
               end
            end
            H_STOP: begin
               if (tick) begin
                  case (q_r)
                     2'h0: oe_r <= 1'b1;
                     2'h1: scl_r <= 1'b1;
                     2'h2: oe_r <= 1'b0;
                     default: begin
                        st_r   <= H_IDLE;
                        done_r <= 1'b1;
                        busy_r <= 1'b0;
                     end
                  endcase
               end
            end
            default: st_r <= H_IDLE;
         endcase
      end
   end

   assign bus.scl      = scl_r;
   assign bus.sda_h_oe = oe_r;
   assign bus.sda_h_o  = 1'b0;
   assign busy_out     = busy_r;
   assign done_out     = done_r;
   assign nack_out     = nack_r;
   assign rdata_out    = rdat_r;
   assign rvalid_out   = rv_r;
endmodule : hcs_host_end

// *** dv/hcs_link_checker.sv ***
// Assertions watching the two-wire bus between the two ends.
`timescale 1ns/1ns
module hcs_link_checker (
   input wire logic clk_sys_in,
   input wire logic nrst_in,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_d_o_in,
   input wire logic sda_d_oe_in
);
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!nrst_in);
   sequence s_start;
      scl_in && $past(scl_in) && $fell(sda_in);
   endsequence
   sequence s_stop;
      scl_in && $past(scl_in) && $rose(sda_in);
   endsequence
   a_dev_open_drain: assert property (!sda_d_o_in)
      else $error("device drives data high");
   a_dev_change_low: assert property (
      $changed(sda_d_oe_in) |-> !scl_in)
      else $error("device moved data while clock high");
   a_dev_hold_high: assert property (
      $rose(scl_in) |-> $stable(sda_d_oe_in)[*8])
      else $error("device data unstable in clock high");
   a_no_dev_start: assert property (s_start |-> !sda_d_oe_in)
      else $error("device pulled data at start");
   a_free_at_stop: assert property (
      s_stop |-> !$past(sda_d_oe_in))
      else $error("device held data at stop");
   a_scl_high_min: assert property ($rose(scl_in) |=> scl_in[*8])
      else $error("clock high phase too short");
   a_scl_low_min: assert property ($fell(scl_in) |=> !scl_in[*8])
      else $error("clock low phase too short");
   a_bit_ends: assert property (
      $rose(sda_d_oe_in) |-> ##[1:300] $fell(scl_in))
      else $error("device bit not ended by clock");
endmodule : hcs_link_checker

// *** dv/tb_top.sv ***
// Self-checking bench joining host end and device end.
`timescale 1ns/1ns
module tb_top;
   import hcs_pkg::*;
   logic         clk_sys_in = 1'b0;
   logic         nrst_in = 1'b0;
   logic         dev_sel = 1'b0;
   logic         host_sel = 1'b0;
   logic         test_mode_in = 1'b0;
   logic         host_xfer_in = 1'b0;
   hcs_word_type mem_rdata_in = 24'h000000;
   hcs_addr_type mem_addr_out;
   hcs_word_type mem_wdata_out;
   logic         mem_wr_out;
   logic         mem_rd_out;
   logic         cmd_class_out;
   logic         test_sdi_out;
   logic         cmd_go_in = 1'b0;
   logic         cmd_read_in = 1'b0;
   hcs_addr_type cmd_addr_in = 16'h0000;
   hcs_word_type cmd_wdata_in = 24'h000000;
   logic         done_out;
   logic         busy_out;
   logic         active_out;
   logic         rd_d = 1'b0;
   logic         nack_out;
   hcs_word_type rdata_out;
   logic         rvalid_out;
   logic         last_nack;
   hcs_addr_type wr_a;
   hcs_word_type wr_d;
   int           wr_n = 0;
   int           mismatches = 0;
   int           n_tests = 0;
   hcs_word_type rq[$];
   hcs_addr_type wa[4] = '{16'h47ff, 16'h0fff, 16'h0fe7, 16'h1000};
   hcs_addr_type ra[2] = '{16'h47fe, 16'h0fee};
   hcs_i2c_if bus_if();
   hcs_dev_end hcs_dev_end_i (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
      .ce_in(1'b1), .addr_sel_in(dev_sel), .test_mode_in(test_mode_in),
      .host_xfer_in(host_xfer_in), .mem_rdata_in(mem_rdata_in),
      .bus(bus_if), .mem_addr_out(mem_addr_out),
      .mem_wdata_out(mem_wdata_out), .mem_wr_out(mem_wr_out),
      .mem_rd_out(mem_rd_out), .cmd_class_out(cmd_class_out),
      .test_sdi_out(test_sdi_out), .active_out(active_out));
   hcs_host_end hcs_host_end_i (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
      .ce_in(1'b1), .cmd_go_in(cmd_go_in), .cmd_read_in(cmd_read_in),
      .cmd_addr_in(cmd_addr_in), .cmd_wdata_in(cmd_wdata_in),
      .cmd_words_in(8'h02), .addr_sel_in(host_sel), .bus(bus_if),
      .busy_out(busy_out), .done_out(done_out), .nack_out(nack_out),
      .rdata_out(rdata_out), .rvalid_out(rvalid_out));
   hcs_link_checker hcs_link_checker_i (.clk_sys_in(clk_sys_in),
      .nrst_in(nrst_in), .scl_in(bus_if.scl), .sda_in(bus_if.sda),
      .sda_d_o_in(bus_if.sda_d_o), .sda_d_oe_in(bus_if.sda_d_oe));
   function automatic hcs_word_type mem_word(input hcs_addr_type a);
      return {a[7:0] ^ 8'h96, a ^ 16'h5ac3};
   endfunction : mem_word
   function automatic hcs_word_type fit(input hcs_addr_type a,
                                        input hcs_word_type w);
      // Short words keep their upper byte at zero.
      if ((a >= 16'h4000 && a <= 16'h47ff) || a == 16'h0fff)
         return {8'h00, w[15:0]};
      return w;
   endfunction : fit
   task automatic check(input hcs_word_type seen, input hcs_word_type exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic test_done;
      $display("mismatches %0d comparisons %0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : test_done
   task automatic run(input logic rd, input hcs_addr_type a,
                      input hcs_word_type d, input logic hs, input logic ds);
      int k;
      @(negedge clk_sys_in);
      cmd_go_in = 1'b1;
      cmd_read_in = rd;
      cmd_addr_in = a;
      cmd_wdata_in = d;
      host_sel = hs;
      dev_sel = ds;
      @(negedge clk_sys_in);
      cmd_go_in = 1'b0;
      check(24'(busy_out), 24'h1);
      for (k = 0; k < 40000 && done_out !== 1'b1; k++)
         @(negedge clk_sys_in);
      if (k == 40000)
         mismatches++;
      last_nack = nack_out;
      check(24'(active_out), 24'h0);
   endtask : run
   initial begin
      forever #5 clk_sys_in = ~clk_sys_in;
   end
   // The processor transfer runs two cycles after each fetch request,
   // once the request is pending in the port.
   always @(negedge clk_sys_in) begin
      rd_d <= mem_rd_out;
      host_xfer_in <= rd_d;
      if (mem_rd_out === 1'b1)
         mem_rdata_in <= mem_word(mem_addr_out);
      if (mem_wr_out === 1'b1) begin
         wr_n <= wr_n + 1;
         wr_a <= mem_addr_out;
         wr_d <= mem_wdata_out;
      end
      if (rvalid_out === 1'b1)
         rq.push_back(rdata_out);
   end
   initial begin
      repeat (105000) @(posedge clk_sys_in);
      mismatches++;
      test_done();
   end
   initial begin
      hcs_addr_type a;
      hcs_word_type d;
      logic s;
      int n;
      void'($urandom(32'h87caa980));
      repeat (16) @(negedge clk_sys_in);
      nrst_in = 1'b1;
      for (int i = 0; i < 4; i++) begin
         test_mode_in = i[1];
         dev_sel = i[0];
         repeat (5) @(negedge clk_sys_in);
         check(24'(test_sdi_out), 24'(i[1] & i[0]));
      end
      for (int i = 0; i < 4; i++) begin
         a = (i == 3) ? 16'h1000 + 16'($urandom_range(16'h2fff)) : wa[i];
         d = 24'($urandom);
         s = 1'($urandom);
         n = wr_n;
         run(1'b0, a, d, s, s);
         check(24'(last_nack), 24'h0);
         check(24'(wr_n - n), 24'h1);
         check(24'(wr_a), 24'(a));
         check(wr_d, fit(a, d));
         check(24'(cmd_class_out),
               24'(a == 16'h0fff || a[15:4] == 12'h0fe));
      end
      n = wr_n;
      run(1'b0, 16'h4000, 24'h00a5a5, 1'b1, 1'b0);
      check(24'(last_nack), 24'h1);
      check(24'(wr_n - n), 24'h0);
      for (int i = 0; i < 2; i++) begin
         rq.delete();
         s = 1'($urandom);
         run(1'b1, ra[i], 24'h000000, s, s);
         check(24'(last_nack), 24'h0);
         check(24'(rq.size()), 24'h2);
         for (int j = 0; j < 2; j++) begin
            a = ra[i] + 16'(j);
            check(rq[j], fit(a, mem_word(a)));
         end
      end
      test_done();
   end
endmodule : tb_top
